/* File: hw/cfc_consts.svh */
// constants of the configurable fifo core: widths, offsets, field positions, reset values
`ifndef CFC_CONSTS_SVH
`define CFC_CONSTS_SVH

`define CFC_DATA_W 16
`define CFC_RDATA_W 8
`define CFC_USED_W 4
`define CFC_DEPTH 16
`define CFC_SYNC_STAGES 2

`define CFC_OFS_CTRL 8'h00
`define CFC_OFS_AF_THR 8'h04
`define CFC_OFS_AE_THR 8'h08
`define CFC_OFS_STATUS 8'h0C
`define CFC_OFS_IRQ_STAT 8'h10
`define CFC_OFS_IRQ_CLR 8'h14
`define CFC_OFS_IRQ_EN 8'h18

`define CFC_CTRL_DUAL 0
`define CFC_CTRL_RATIO 1
`define CFC_CTRL_AHEAD 2
`define CFC_CTRL_OVF_CHK 3
`define CFC_CTRL_UDF_CHK 4
`define CFC_CTRL_XMSB 5
`define CFC_CTRL_W 6
`define CFC_CTRL_RST 6'h18

`define CFC_AF_THR_RST 6'h0C
`define CFC_AE_THR_RST 6'h04
`define CFC_THR_W 6

`define CFC_ST_FULL 0
`define CFC_ST_EMPTY 1
`define CFC_ST_AF 2
`define CFC_ST_AE 3
`define CFC_ST_WR_USED 8
`define CFC_ST_RD_USED 16

`define CFC_IRQ_OVF 0
`define CFC_IRQ_UDF 1
`define CFC_IRQ_AF 2
`define CFC_IRQ_W 3

`endif

/* File: hw/cfc_pkg.sv */
// types and shared functions of the configurable fifo core
package cfc_pkg;
`include "cfc_consts.svh"

   typedef logic [`CFC_DATA_W-1:0] cfc_data_t;
   typedef logic [`CFC_USED_W-1:0] cfc_addr_t;
   typedef logic [`CFC_USED_W:0] cfc_ptr_t;
   typedef logic [`CFC_USED_W+1:0] cfc_hptr_t;

   function automatic cfc_ptr_t cfc_bin2gray(input cfc_ptr_t b);
      cfc_bin2gray = b ^ (b >> 1);
   endfunction : cfc_bin2gray

   function automatic cfc_ptr_t cfc_gray2bin(input cfc_ptr_t g);
      cfc_ptr_t b;
      b[`CFC_USED_W] = g[`CFC_USED_W];
      for (int i = `CFC_USED_W - 1; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      cfc_gray2bin = b;
   endfunction : cfc_gray2bin

endpackage : cfc_pkg

/* File: hw/cfc_mem.sv */
// storage array of the fifo with registered, optionally narrowed read data
`timescale 1ns/10ps
`include "cfc_consts.svh"
module cfc_mem
   import cfc_pkg::*;
(
   input wire logic clk_in,
   input wire logic wr_en_in,
   input wire cfc_addr_t wr_addr_in,
   input wire cfc_data_t wr_data_in,
   input wire logic rd_en_in,
   input wire cfc_addr_t rd_addr_in,
   input wire logic rd_half_in,
   input wire logic rd_narrow_in,
   output cfc_data_t rd_data_out
);
   cfc_data_t store [`CFC_DEPTH];
   wire logic bypass = wr_en_in && (wr_addr_in == rd_addr_in);
   wire cfc_data_t word = bypass ? wr_data_in : store[rd_addr_in];
   wire logic [`CFC_RDATA_W-1:0] narrow_word = rd_half_in ? word[`CFC_DATA_W-1:`CFC_RDATA_W] :
                                                            word[`CFC_RDATA_W-1:0];
   wire cfc_data_t shaped = rd_narrow_in ? {{(`CFC_DATA_W-`CFC_RDATA_W){1'b0}}, narrow_word} : word;

   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         store[wr_addr_in] <= wr_data_in;
      end
   end

   // new data written to the shown address passes straight through
   always_ff @(posedge clk_in) begin
      if (rd_en_in) begin
         rd_data_out <= shaped;
      end
   end
endmodule : cfc_mem

/* File: hw/cfc_gray_sync.sv */
// gray-coded pointer crossing with a multi-stage synchroniser
`timescale 1ns/10ps
`include "cfc_consts.svh"
module cfc_gray_sync
   import cfc_pkg::*;
(
   input wire logic clk_in,
   input wire logic clr_in,
   input wire cfc_ptr_t bin_in,
   output cfc_ptr_t bin_out
);
   cfc_ptr_t gray_src;
   cfc_ptr_t stage [`CFC_SYNC_STAGES];

   always_ff @(posedge clk_in) begin
      if (clr_in) begin
         gray_src <= '0;
         for (int i = 0; i < `CFC_SYNC_STAGES; i++) begin
            stage[i] <= '0;
         end
      end else begin
         gray_src <= cfc_bin2gray(bin_in);
         stage[0] <= gray_src;
         for (int i = 1; i < `CFC_SYNC_STAGES; i++) begin
            stage[i] <= stage[i-1];
         end
      end
   end

   assign bin_out = cfc_gray2bin(stage[`CFC_SYNC_STAGES-1]);
endmodule : cfc_gray_sync

/* File: hw/cfc_core.sv */
// configurable fifo core: single, dual-rate and width-ratio variants with register port
`timescale 1ns/10ps
`include "cfc_consts.svh"
module cfc_core
   import cfc_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_STB_IN,
   input wire logic RD_STB_IN,
   output logic [31:0] RDATA_OUT,
   output logic IRQ_OUT,
   input wire logic WR_CE_IN,
   input wire logic WR_REQ_IN,
   input wire cfc_data_t WR_DATA_IN,
   input wire logic RD_CE_IN,
   input wire logic RD_REQ_IN,
   output cfc_data_t RD_DATA_OUT,
   output logic WR_FULL_OUT,
   output logic RD_EMPTY_OUT,
   output logic ALMOST_FULL_OUT,
   output logic ALMOST_EMPTY_OUT,
   output logic [`CFC_USED_W:0] WR_USED_OUT,
   output logic [`CFC_USED_W+1:0] RD_USED_OUT
);
   // configuration and interrupt registers
   logic [`CFC_CTRL_W-1:0] ctrl;
   logic [`CFC_THR_W-1:0] af_thr;
   logic [`CFC_THR_W-1:0] ae_thr;
   logic [`CFC_IRQ_W-1:0] irq_stat;
   logic [`CFC_IRQ_W-1:0] irq_en;

   // pointers: write in words, read in half words
   cfc_ptr_t wr_ptr;
   cfc_hptr_t rd_hptr;
   cfc_ptr_t wr_sync;
   cfc_ptr_t rd_sync;

   // register port decode
   wire logic sel_ctrl = ADDR_IN == `CFC_OFS_CTRL;
   wire logic sel_af = ADDR_IN == `CFC_OFS_AF_THR;
   wire logic sel_ae = ADDR_IN == `CFC_OFS_AE_THR;
   wire logic sel_status = ADDR_IN == `CFC_OFS_STATUS;
   wire logic sel_istat = ADDR_IN == `CFC_OFS_IRQ_STAT;
   wire logic sel_iclr = ADDR_IN == `CFC_OFS_IRQ_CLR;
   wire logic sel_ien = ADDR_IN == `CFC_OFS_IRQ_EN;
   wire logic ctrl_wr = WR_STB_IN && sel_ctrl;

   // control fields
   wire logic dual_mode = ctrl[`CFC_CTRL_DUAL];
   wire logic ratio_mode = dual_mode && ctrl[`CFC_CTRL_RATIO];
   wire logic ahead_mode = ctrl[`CFC_CTRL_AHEAD];
   wire logic ovf_chk = ctrl[`CFC_CTRL_OVF_CHK];
   wire logic udf_chk = ctrl[`CFC_CTRL_UDF_CHK];
   wire logic xmsb_on = dual_mode && ctrl[`CFC_CTRL_XMSB];

   // each side runs at its own enable rate only in the dual variant
   wire logic wr_ce = dual_mode ? WR_CE_IN : 1'b1;
   wire logic rd_ce = dual_mode ? RD_CE_IN : 1'b1;

   // accepted transfers
   wire logic wr_try = WR_REQ_IN && wr_ce;
   wire logic rd_try = RD_REQ_IN && rd_ce;
   wire logic wr_go = wr_try && (!WR_FULL_OUT || !ovf_chk);
   wire logic rd_go = rd_try && (!RD_EMPTY_OUT || !udf_chk);

   // a ratio read takes one half word, any other read a whole word
   wire cfc_hptr_t rd_step = ratio_mode ? cfc_hptr_t'(1) : cfc_hptr_t'(2);

   wire cfc_ptr_t next_wr_ptr = ctrl_wr ? '0 : (wr_go ? wr_ptr + cfc_ptr_t'(1) : wr_ptr);
   wire cfc_hptr_t next_rd_hptr = ctrl_wr ? '0 : (rd_go ? rd_hptr + rd_step : rd_hptr);
   wire cfc_ptr_t next_rd_word = next_rd_hptr[`CFC_USED_W+1:1];

   // each side sees the other pointer directly, or through the crossing
   // the crossing still holds old pointers while a control write flushes, so it is masked then
   wire cfc_ptr_t wr_vis_next = ctrl_wr ? '0 : (dual_mode ? wr_sync : next_wr_ptr);
   wire cfc_ptr_t rd_vis_next = ctrl_wr ? '0 : (dual_mode ? rd_sync : next_rd_word);

   // fill counts of both sides from the next pointer values
   wire cfc_ptr_t wr_used_next = next_wr_ptr - rd_vis_next;
   wire cfc_ptr_t rd_words_next = wr_vis_next - next_rd_word;
   wire cfc_hptr_t rd_halves_next = {wr_vis_next, 1'b0} - next_rd_hptr;
   wire cfc_hptr_t rd_count_next = ratio_mode ? rd_halves_next : cfc_hptr_t'(rd_words_next);

   wire logic full_next = wr_used_next[`CFC_USED_W];
   wire logic empty_next = rd_halves_next == '0;
   wire logic af_next = cfc_hptr_t'(wr_used_next) >= cfc_hptr_t'(af_thr);
   wire logic ae_next = rd_count_next < cfc_hptr_t'(ae_thr);

   // without the extra bit a full buffer wraps its count to zero
   wire logic [`CFC_USED_W:0] wr_used_shown = xmsb_on ? wr_used_next :
                                              {1'b0, wr_used_next[`CFC_USED_W-1:0]};
   wire cfc_hptr_t rd_words_shown = xmsb_on ? cfc_hptr_t'(rd_words_next) :
                                    cfc_hptr_t'(rd_words_next[`CFC_USED_W-1:0]);
   wire cfc_hptr_t rd_halves_shown = xmsb_on ? rd_halves_next :
                                     cfc_hptr_t'(rd_halves_next[`CFC_USED_W:0]);
   wire cfc_hptr_t rd_used_shown = ratio_mode ? rd_halves_shown : rd_words_shown;

   // read port of the store: look-ahead keeps fetching the head, normal fetches on request
   wire logic mem_rd_en = ahead_mode ? 1'b1 : (rd_go || ctrl_wr);
   wire cfc_hptr_t mem_rd_pos = ahead_mode ? next_rd_hptr : rd_hptr;

   // interrupt events
   wire logic [`CFC_IRQ_W-1:0] irq_event;
   assign irq_event[`CFC_IRQ_OVF] = wr_try && WR_FULL_OUT;
   assign irq_event[`CFC_IRQ_UDF] = rd_try && RD_EMPTY_OUT;
   assign irq_event[`CFC_IRQ_AF] = af_next && !ALMOST_FULL_OUT;
   wire logic [`CFC_IRQ_W-1:0] irq_clr = (WR_STB_IN && sel_iclr) ? WDATA_IN[`CFC_IRQ_W-1:0] : '0;
   // a new event wins over a clear in the same cycle
   wire logic [`CFC_IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_event;
   wire logic [`CFC_IRQ_W-1:0] next_irq_en = (WR_STB_IN && sel_ien) ? WDATA_IN[`CFC_IRQ_W-1:0] : irq_en;

   // read data mux
   wire logic [31:0] status_word = (32'(WR_FULL_OUT) << `CFC_ST_FULL)
                                 | (32'(RD_EMPTY_OUT) << `CFC_ST_EMPTY)
                                 | (32'(ALMOST_FULL_OUT) << `CFC_ST_AF)
                                 | (32'(ALMOST_EMPTY_OUT) << `CFC_ST_AE)
                                 | (32'(WR_USED_OUT) << `CFC_ST_WR_USED)
                                 | (32'(RD_USED_OUT) << `CFC_ST_RD_USED);
   wire logic [31:0] rd_word = sel_ctrl ? 32'(ctrl) :
                               sel_af ? 32'(af_thr) :
                               sel_ae ? 32'(ae_thr) :
                               sel_status ? status_word :
                               sel_istat ? 32'(irq_stat) :
                               sel_ien ? 32'(irq_en) : 32'h00000000;
   wire logic [31:0] next_rdata = RD_STB_IN ? rd_word : 32'h00000000;

   cfc_mem u_mem (
      .clk_in(SYS_CLK_IN),
      .wr_en_in(wr_go),
      .wr_addr_in(wr_ptr[`CFC_USED_W-1:0]),
      .wr_data_in(WR_DATA_IN),
      .rd_en_in(mem_rd_en),
      .rd_addr_in(mem_rd_pos[`CFC_USED_W:1]),
      .rd_half_in(mem_rd_pos[0]),
      .rd_narrow_in(ratio_mode),
      .rd_data_out(RD_DATA_OUT)
   );

   cfc_gray_sync u_wr_to_rd (
      .clk_in(SYS_CLK_IN),
      .clr_in(RST_IN || ctrl_wr),
      .bin_in(wr_ptr),
      .bin_out(wr_sync)
   );

   cfc_gray_sync u_rd_to_wr (
      .clk_in(SYS_CLK_IN),
      .clr_in(RST_IN || ctrl_wr),
      .bin_in(rd_hptr[`CFC_USED_W+1:1]),
      .bin_out(rd_sync)
   );

   // register file; a control write also empties the buffer
   always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
         ctrl <= `CFC_CTRL_RST;
         af_thr <= `CFC_AF_THR_RST;
         ae_thr <= `CFC_AE_THR_RST;
         irq_stat <= '0;
         irq_en <= '0;
         RDATA_OUT <= 32'h00000000;
         IRQ_OUT <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            ctrl <= WDATA_IN[`CFC_CTRL_W-1:0];
         end
         if (WR_STB_IN && sel_af) begin
            af_thr <= WDATA_IN[`CFC_THR_W-1:0];
         end
         if (WR_STB_IN && sel_ae) begin
            ae_thr <= WDATA_IN[`CFC_THR_W-1:0];
         end
         irq_stat <= next_irq_stat;
         irq_en <= next_irq_en;
         RDATA_OUT <= next_rdata;
         IRQ_OUT <= |(next_irq_stat & next_irq_en);
      end
   end

   // pointers and registered flags
   always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
         wr_ptr <= '0;
         rd_hptr <= '0;
         WR_FULL_OUT <= 1'b0;
         RD_EMPTY_OUT <= 1'b1;
         ALMOST_FULL_OUT <= 1'b0;
         ALMOST_EMPTY_OUT <= 1'b1;
         WR_USED_OUT <= '0;
         RD_USED_OUT <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_hptr <= next_rd_hptr;
         WR_FULL_OUT <= full_next;
         RD_EMPTY_OUT <= empty_next;
         ALMOST_FULL_OUT <= af_next;
         ALMOST_EMPTY_OUT <= ae_next;
         WR_USED_OUT <= wr_used_shown;
         RD_USED_OUT <= rd_used_shown;
      end
   end
endmodule : cfc_core

/* File: verif/cfc_user.sv */
// far-side user logic: write and read requesters that watch the flags
`timescale 1ns/10ps
module cfc_user
   import cfc_pkg::*;
(
   input wire logic want_wr_in,
   input wire logic want_rd_in,
   input wire logic rude_in,
   input wire logic full_in,
   input wire logic empty_in,
   input wire cfc_data_t word_in,
   output logic wr_req_out,
   output logic rd_req_out,
   output cfc_data_t wr_data_out
);
   // rude_in lets a scenario ignore the flags on purpose
   assign wr_req_out = want_wr_in && (rude_in || !full_in);
   assign rd_req_out = want_rd_in && (rude_in || !empty_in);
   // data lines show the inverted word while no write is offered
   assign wr_data_out = wr_req_out ? word_in : ~word_in;
endmodule : cfc_user

/* File: verif/cfc_core_asserts.sv */
// concurrent checks on the ports of the configurable fifo core
`timescale 1ns/10ps
`include "cfc_consts.svh"
module cfc_core_asserts
   import cfc_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_STB_IN,
   input wire logic WR_REQ_IN,
   input wire logic RD_REQ_IN,
   input wire cfc_data_t RD_DATA_OUT,
   input wire logic WR_FULL_OUT,
   input wire logic RD_EMPTY_OUT,
   input wire logic ALMOST_FULL_OUT,
   input wire logic ALMOST_EMPTY_OUT,
   input wire logic [`CFC_USED_W:0] WR_USED_OUT
);
   logic [5:0] md, af_thr, ae_thr;
   logic got;
   wire [5:0] cnt = {1'b0, WR_FULL_OUT, WR_USED_OUT[3:0]};
   // single variant and no register write this cycle
   wire sg = !md[0] && !WR_STB_IN;
   wire sn = sg && !md[2];
   always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
         md <= 6'h18;
         af_thr <= 6'h0C;
         ae_thr <= 6'h04;
         got <= 1'b0;
      end else begin
         if (WR_STB_IN && ADDR_IN == 8'h00) md <= WDATA_IN[5:0];
         if (WR_STB_IN && ADDR_IN == 8'h04) af_thr <= WDATA_IN[5:0];
         if (WR_STB_IN && ADDR_IN == 8'h08) ae_thr <= WDATA_IN[5:0];
         if (RD_REQ_IN && !RD_EMPTY_OUT) got <= 1'b1;
      end
   end
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (RST_IN);
   chk_full_drop: assert property (sg && md[3] && WR_FULL_OUT && WR_REQ_IN && !RD_REQ_IN
      |=> WR_FULL_OUT && cnt == 6'h10) else $error("write into full buffer not dropped");
   chk_empty_drop: assert property (sn && md[4] && got && RD_EMPTY_OUT && RD_REQ_IN && !WR_REQ_IN
      |=> RD_EMPTY_OUT && $stable(RD_DATA_OUT)) else $error("read of empty buffer not dropped");
   chk_count_up: assert property (sg && WR_REQ_IN && !WR_FULL_OUT && !RD_REQ_IN
      |=> cnt == $past(cnt) + 6'h01) else $error("count did not rise on write");
   chk_count_down: assert property (sg && RD_REQ_IN && !RD_EMPTY_OUT && !WR_REQ_IN
      |=> cnt == $past(cnt) - 6'h01) else $error("count did not fall on read");
   chk_count_both: assert property (sg && WR_REQ_IN && RD_REQ_IN && !WR_FULL_OUT && !RD_EMPTY_OUT
      |=> $stable(cnt)) else $error("count moved on read with write");
   chk_near_full: assert property (sg && !$past(WR_STB_IN) |-> ALMOST_FULL_OUT == (cnt >= af_thr))
      else $error("near-full flag wrong");
   chk_near_empty: assert property (sg && !$past(WR_STB_IN) |-> ALMOST_EMPTY_OUT == (cnt < ae_thr))
      else $error("near-empty flag wrong");
   chk_data_hold: assert property (sn && got && !RD_REQ_IN |=> $stable(RD_DATA_OUT))
      else $error("read data changed without read");
   chk_head_hold: assert property (sg && md[2] && md[3] && !RD_EMPTY_OUT && !RD_REQ_IN
      |=> !RD_EMPTY_OUT && $stable(RD_DATA_OUT)) else $error("shown word changed without acknowledge");
endmodule : cfc_core_asserts
bind cfc_core cfc_core_asserts chk (.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN),
   .WDATA_IN(WDATA_IN), .WR_STB_IN(WR_STB_IN), .WR_REQ_IN(WR_REQ_IN), .RD_REQ_IN(RD_REQ_IN),
   .RD_DATA_OUT(RD_DATA_OUT), .WR_FULL_OUT(WR_FULL_OUT), .RD_EMPTY_OUT(RD_EMPTY_OUT),
   .ALMOST_FULL_OUT(ALMOST_FULL_OUT), .ALMOST_EMPTY_OUT(ALMOST_EMPTY_OUT), .WR_USED_OUT(WR_USED_OUT));

/* File: verif/cfc_core_tb.sv */
// self-checking bench of the configurable fifo core against a queue model
`timescale 1ns/10ps
module cfc_core_tb;
   import cfc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wstb = 1'b0, rstb = 1'b0, want_wr = 1'b0, want_rd = 1'b0, rude = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdat = 32'h0, rdata;
   cfc_data_t word = 16'h0, wd, rd_data, exp_rd;
   logic wreq, rreq, irq, full, empty, af, ae;
   logic single = 1'b1, ahead = 1'b0, ratio = 1'b0, half = 1'b0, chk_rd = 1'b0;
   logic wce = 1'b1, rce = 1'b1;
   logic [31:0] rnd;
   logic [4:0] wu;
   logic [5:0] ru;
   int miscompares = 0, checked = 0, seed = 32;
   cfc_data_t q[$];
   cfc_core dut (.SYS_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdat), .WR_STB_IN(wstb),
      .RD_STB_IN(rstb), .RDATA_OUT(rdata), .IRQ_OUT(irq), .WR_CE_IN(wce), .WR_REQ_IN(wreq),
      .WR_DATA_IN(wd), .RD_CE_IN(rce), .RD_REQ_IN(rreq), .RD_DATA_OUT(rd_data), .WR_FULL_OUT(full),
      .RD_EMPTY_OUT(empty), .ALMOST_FULL_OUT(af), .ALMOST_EMPTY_OUT(ae), .WR_USED_OUT(wu), .RD_USED_OUT(ru));
   cfc_user usr (.want_wr_in(want_wr), .want_rd_in(want_rd), .rude_in(rude), .full_in(full),
      .empty_in(empty), .word_in(word), .wr_req_out(wreq), .rd_req_out(rreq), .wr_data_out(wd));
   initial begin
      forever #5 clk = ~clk;
   end
   task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : cmp
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      wstb <= w;
      rstb <= !w;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      wstb <= 1'b0;
      rstb <= 1'b0;
      #1 if (!w) cmp("reg", d, rdata);
      @(posedge clk);
   endtask : bus
   task irqchk(input logic [7:0] a, input logic [31:0] d, input logic e);
      bus(1'b1, a, d);
      #1 cmp("irq", e, irq);
      @(posedge clk);
   endtask : irqchk
   // one user cycle: check the previous cycle's results, then update the model
   task step(input logic w, input logic r, input logic x, input cfc_data_t d);
      rnd = $random(seed);
      want_wr <= w;
      want_rd <= r;
      rude <= x;
      word <= d;
      // dual variant: random read-side rate, and random write-side rate in the ratio build
      wce <= single || !ratio || rnd[0] || rnd[3];
      rce <= single || rnd[1] || rnd[2];
      #1 if (chk_rd) cmp("rd_data", exp_rd, rd_data);
      if (single) begin
         cmp("wused", q.size() % 16, wu);
         cmp("rused", q.size() % 16, ru);
         cmp("full", q.size() == 16, full);
         cmp("empty", q.size() == 0, empty);
         cmp("af", q.size() >= 12, af);
         cmp("ae", q.size() < 4, ae);
         if (ahead && q.size() != 0) cmp("head", q[0], rd_data);
      end
      chk_rd = 1'b0;
      if (rreq && (single || rce) && q.size() != 0) begin
         exp_rd = ratio ? (half ? q[0] >> 8 : q[0] & 16'h00FF) : q[0];
         if (!ratio || half) void'(q.pop_front());
         half = ratio && !half;
         chk_rd = !ahead;
      end
      if (wreq && (single || wce) && q.size() < 16) q.push_back(d);
      @(posedge clk);
   endtask : step
   task mode(input logic [7:0] c);
      bus(1'b1, 8'h00, {24'h0, c});
      q.delete();
      single = !c[0];
      ahead = c[2];
      ratio = c[1];
      half = 1'b0;
   endtask : mode
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      #400000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, 8'h00, 32'h18);
      bus(1'b0, 8'h04, 32'h0C);
      bus(1'b0, 8'h08, 32'h04);
      bus(1'b0, 8'h1C, 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 18; i++) step(i < 17, 1'b0, 1'b1, cfc_data_t'($random(seed)));
      bus(1'b0, 8'h10, 32'h5);
      irqchk(8'h18, 32'h1, 1'b1);
      irqchk(8'h18, 32'h2, 1'b0);
      irqchk(8'h14, 32'h7, 1'b0);
      for (int i = 0; i < 18; i++) step(1'b0, i < 17, 1'b1, 16'h0);
      bus(1'b0, 8'h10, 32'h2);
      #1 cmp("irq", 1'b1, irq);
      @(posedge clk);
      irqchk(8'h14, 32'h7, 1'b0);
      $display("test fill and drain done");
      for (int i = 0; i < 20; i++) step(i < 14, i > 4, 1'b0, cfc_data_t'($random(seed)));
      step(1'b0, 1'b0, 1'b0, 16'h0);
      $display("test concurrent traffic done");
      mode(8'h1C);
      for (int i = 0; i < 12; i++) step(i < 4, i > 5, 1'b0, cfc_data_t'($random(seed)));
      $display("test look-ahead done");
      mode(8'h39);
      step(1'b1, 1'b0, 1'b0, cfc_data_t'($random(seed)));
      #1 cmp("lag", 1'b1, empty);
      for (int i = 0; i < 20; i++) step(i < 16, 1'b0, 1'b0, cfc_data_t'($random(seed)));
      #1 cmp("wused", 16, wu);
      cmp("rused", 16, ru);
      @(posedge clk);
      for (int i = 0; i < 22; i++) step(1'b0, i < 18, 1'b0, 16'h0);
      $display("test dual variant done");
      mode(8'h1B);
      for (int i = 0; i < 12; i++) step(i < 4, i > 5, 1'b0, cfc_data_t'($random(seed)));
      $display("test ratio variant done");
      tally_and_finish();
   end
endmodule : cfc_core_tb
